// ---- verilog/scio_consts.svh ----
`ifndef SCIO_CONSTS_SVH
`define SCIO_CONSTS_SVH
// ==========================================================
// register byte addresses (one aligned word each)
`define SCIO_ADR_CTRL      8'h00
`define SCIO_ADR_SERSEL    8'h04
`define SCIO_ADR_STAT      8'h08
`define SCIO_ADR_MASK      8'h0c
`define SCIO_ADR_IDENT     8'h10
`define SCIO_ADR_WT0       8'h14
`define SCIO_ADR_WT1       8'h18
`define SCIO_ADR_WT2       8'h1c
`define SCIO_ADR_WT3       8'h20
`define SCIO_ADR_TXD       8'h24
`define SCIO_ADR_RXD       8'h28
`define SCIO_ADR_CONTACTS  8'hac
// ==========================================================
// field positions
`define SCIO_CTRL_UART     3
`define SCIO_CTRL_WAIT_COUNTER_ENABLE     2
`define SCIO_CTRL_REPETITION_ENABLE     1
`define SCIO_CTRL_CONVENTION_SELECT     0
`define SCIO_SER_REPSEL    0
`define SCIO_SER_PAGE      1
`define SCIO_ST_PE         0
`define SCIO_ST_WTO        1
`define SCIO_ST_TXD        2
`define SCIO_ST_RXD        3
`define SCIO_CON_IO        3
// ==========================================================
// reset values
`define SCIO_CTRL_RST      8'h00
`define SCIO_CON_RST       8'h00
// ==========================================================
// timing counts, in card clock edges and elementary time units
`define SCIO_ETU_CLKS      9'h174
`define SCIO_ETU_HALF      9'h0ba
`define SCIO_RX_SIG_LO     3'h4
`define SCIO_RX_SIG_HI     3'h5
`define SCIO_TX_REP_LO     3'h3
`define SCIO_TX_REP_HI     3'h4
`define SCIO_TX_GUARD_LAST 4'h2
`define SCIO_RX_SIG_LAST   4'h2
`define SCIO_PARITY_BIT    4'h9
`endif

// ---- verilog/scio_pkg.sv ----
package scio_pkg;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_TX       = 3'b001,
    ST_TX_GUARD = 3'b010,
    ST_RX       = 3'b011,
    ST_RX_SIG   = 3'b100
  } scio_state_t;
endpackage

// ---- verilog/scio_top.sv ----
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "scio_consts.svh"
module scio_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        card_clk_i,
  input  wire logic        card_io_i,
  output logic             card_io_o,
  output logic             card_io_oe_o,
  output logic             clk_src_sel_o,
  output logic             contact_c8_level_o,
  output logic             contact_c4_level_o,
  output logic             card_clock_level_o,
  output logic             card_reset_level_o,
  output logic             card_power_on_o
);

  // ==========================================================
  // state
  scio_pkg::scio_state_t st_r, st_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [1:0]  ser_r, ser_nxt;
  logic [3:0]  stat_r, stat_nxt;
  logic [3:0]  mask_r, mask_nxt;
  logic        ident_r, ident_nxt;
  logic [7:0]  wt0_r, wt0_nxt, wt1_r, wt1_nxt, wt2_r, wt2_nxt, wt3_r, wt3_nxt;
  logic [7:0]  txd_r, txd_nxt;
  logic [7:0]  rxd_r, rxd_nxt;
  logic [7:0]  con_r, con_nxt;
  logic        run_r, run_nxt;
  logic [31:0] wcnt_r, wcnt_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic [8:0]  wetu_r, wetu_nxt;
  logic [8:0]  etu_r, etu_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  rxsh_r, rxsh_nxt;
  logic        err_r, err_nxt;
  logic [2:0]  rep_r, rep_nxt;
  logic [2:0]  sig_r, sig_nxt;
  logic        pend_r, pend_nxt;
  logic        oe_r, oe_nxt;
  logic        io_s1_r, io_s2_r, io_s3_r;
  logic        ck_s1_r, ck_s2_r, ck_s3_r;

  // ==========================================================
  // helpers
  logic        req, wr, rd, clk_tick, io_fall, etu_end, mid_etu, wt_tick, char_start;
  logic        uart, repetition_enable, convention_select, repsel, lvl_logic, tx_level, rx_perr;
  logic [2:0]  tx_k, rx_pos, sig_lim, tx_lim;
  logic [3:0]  st_set, st_clr;
  logic [7:0]  rd_byte;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign rd       = req & ~wb_we_i;
  assign clk_tick = ck_s2_r & ~ck_s3_r;
  assign io_fall  = ~io_s2_r & io_s3_r;
  assign etu_end  = clk_tick & (etu_r == (`SCIO_ETU_CLKS - 9'h001));
  assign mid_etu  = clk_tick & (etu_r == `SCIO_ETU_HALF);
  assign uart     = ctrl_r[`SCIO_CTRL_UART];
  assign repetition_enable     = ctrl_r[`SCIO_CTRL_REPETITION_ENABLE];
  assign convention_select     = ctrl_r[`SCIO_CTRL_CONVENTION_SELECT];
  assign repsel   = ser_r[`SCIO_SER_REPSEL];
  assign sig_lim  = repsel ? `SCIO_RX_SIG_HI : `SCIO_RX_SIG_LO;
  assign tx_lim   = repsel ? `SCIO_TX_REP_HI : `SCIO_TX_REP_LO;
  // uart mode counts etus, software mode counts raw card clock edges
  assign wt_tick  = uart ? (clk_tick & (wetu_r == (`SCIO_ETU_CLKS - 9'h001))) : clk_tick;
  assign char_start = (st_r == scio_pkg::ST_IDLE) & (st_nxt != scio_pkg::ST_IDLE);

  // ==========================================================
  // line coding
  assign tx_k   = 3'(bit_r - 4'h1);
  assign rx_pos = convention_select ? (3'h7 - tx_k) : tx_k;
  always_comb begin
    tx_level = 1'b0;
    if (bit_r == `SCIO_PARITY_BIT) begin
      tx_level = convention_select ? ~(^txd_r) : (^txd_r);
    end else if (bit_r != 4'h0) begin
      tx_level = convention_select ? ~txd_r[3'h7 - tx_k] : txd_r[tx_k];
    end
  end
  assign lvl_logic = convention_select ? ~io_s2_r : io_s2_r;
  assign rx_perr   = repetition_enable & (lvl_logic ^ (^rxsh_r));

  // ==========================================================
  // read mux
  always_comb begin
    rd_byte = 8'h00;
    case (wb_adr_i)
      `SCIO_ADR_CTRL:   rd_byte = {ctrl_r[7:3], run_r, ctrl_r[1:0]};
      `SCIO_ADR_SERSEL: rd_byte = {6'h00, ser_r};
      `SCIO_ADR_STAT:   rd_byte = {4'h0, stat_r};
      `SCIO_ADR_MASK:   rd_byte = {4'h0, mask_r};
      `SCIO_ADR_IDENT:  rd_byte = {7'h00, ident_r};
      `SCIO_ADR_WT0:    rd_byte = wt0_r;
      `SCIO_ADR_WT1:    rd_byte = wt1_r;
      `SCIO_ADR_WT2:    rd_byte = wt2_r;
      `SCIO_ADR_WT3:    rd_byte = wt3_r;
      `SCIO_ADR_TXD:    rd_byte = txd_r;
      `SCIO_ADR_RXD:    rd_byte = rxd_r;
      `SCIO_ADR_CONTACTS: begin
        if (!ser_r[`SCIO_SER_PAGE]) begin
          rd_byte = {con_r[7], 1'b0, con_r[5:4], io_s2_r, con_r[2:0]};
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt   = st_r;
    ack_nxt  = req;
    dat_nxt  = rd ? {24'h000000, rd_byte} : 32'h00000000;
    ctrl_nxt = ctrl_r;
    ser_nxt  = ser_r;
    mask_nxt = mask_r;
    wt0_nxt  = wt0_r;
    wt1_nxt  = wt1_r;
    wt2_nxt  = wt2_r;
    wt3_nxt  = wt3_r;
    txd_nxt  = txd_r;
    rxd_nxt  = rxd_r;
    con_nxt  = con_r;
    run_nxt  = run_r;
    wcnt_nxt = wcnt_r;
    hold_nxt = hold_r;
    wetu_nxt = wetu_r;
    etu_nxt  = etu_r;
    bit_nxt  = bit_r;
    rxsh_nxt = rxsh_r;
    err_nxt  = err_r;
    rep_nxt  = rep_r;
    sig_nxt  = sig_r;
    pend_nxt = pend_r;
    st_set   = 4'h0;
    st_clr   = 4'h0;

    // character engine
    if (clk_tick) begin
      etu_nxt = etu_end ? 9'h000 : 9'(etu_r + 9'h001);
    end
    case (st_r)
      scio_pkg::ST_IDLE: begin
        etu_nxt = 9'h000;
        bit_nxt = 4'h0;
        if (uart && pend_r) begin
          st_nxt   = scio_pkg::ST_TX;
          pend_nxt = 1'b0;
        end else if (uart && io_fall) begin
          st_nxt = scio_pkg::ST_RX;
        end
      end
      scio_pkg::ST_TX: begin
        if (etu_end) begin
          if (bit_r == `SCIO_PARITY_BIT) begin
            st_nxt  = scio_pkg::ST_TX_GUARD;
            bit_nxt = 4'h0;
            err_nxt = 1'b0;
          end else begin
            bit_nxt = 4'(bit_r + 4'h1);
          end
        end
      end
      scio_pkg::ST_TX_GUARD: begin
        if (etu_end) begin
          bit_nxt = 4'(bit_r + 4'h1);
          if (bit_r == 4'h0) begin
            err_nxt = ~io_s2_r;
          end
          if (bit_r == `SCIO_TX_GUARD_LAST) begin
            bit_nxt = 4'h0;
            if (err_r && repetition_enable && (rep_r < tx_lim)) begin
              rep_nxt = 3'(rep_r + 3'h1);
              st_nxt  = scio_pkg::ST_TX;
            end else begin
              st_set[`SCIO_ST_PE]  = err_r & repetition_enable;
              st_set[`SCIO_ST_TXD] = 1'b1;
              rep_nxt = 3'h0;
              st_nxt  = scio_pkg::ST_IDLE;
            end
          end
        end
      end
      scio_pkg::ST_RX: begin
        if (mid_etu) begin
          bit_nxt = 4'(bit_r + 4'h1);
          if (bit_r == 4'h0) begin
            if (io_s2_r) begin
              st_nxt = scio_pkg::ST_IDLE;
            end
          end else if (bit_r != `SCIO_PARITY_BIT) begin
            rxsh_nxt[rx_pos] = lvl_logic;
          end else if (rx_perr && (sig_r < sig_lim)) begin
            sig_nxt = 3'(sig_r + 3'h1);
            st_nxt  = scio_pkg::ST_RX_SIG;
            bit_nxt = 4'h0;
            etu_nxt = 9'h000;
          end else begin
            st_set[`SCIO_ST_PE]  = rx_perr;
            st_set[`SCIO_ST_RXD] = 1'b1;
            rxd_nxt = rxsh_r;
            sig_nxt = 3'h0;
            st_nxt  = scio_pkg::ST_IDLE;
          end
        end
      end
      scio_pkg::ST_RX_SIG: begin
        if (etu_end) begin
          bit_nxt = 4'(bit_r + 4'h1);
          if (bit_r == `SCIO_RX_SIG_LAST) begin
            st_nxt = scio_pkg::ST_IDLE;
          end
        end
      end
      default: st_nxt = scio_pkg::ST_IDLE;
    endcase

    // waiting time counter
    if (!run_r) begin
      hold_nxt = {wt3_r, wt2_r, wt1_r, wt0_r};
      wetu_nxt = 9'h000;
    end else begin
      if (clk_tick) begin
        wetu_nxt = (wetu_r == (`SCIO_ETU_CLKS - 9'h001)) ? 9'h000 : 9'(wetu_r + 9'h001);
      end
      if (wcnt_r == hold_r) begin
        run_nxt = 1'b0;
        st_set[`SCIO_ST_WTO] = 1'b1;
      end else if (uart && char_start) begin
        wcnt_nxt = 32'h00000000;
        wetu_nxt = 9'h000;
      end else if (wt_tick) begin
        wcnt_nxt = 32'(wcnt_r + 32'h00000001);
      end
    end

    // register writes
    if (wr) begin
      case (wb_adr_i)
        `SCIO_ADR_CTRL: begin
          ctrl_nxt = wb_dat_i[7:0];
          ctrl_nxt[`SCIO_CTRL_WAIT_COUNTER_ENABLE] = 1'b0;
          if (wb_dat_i[`SCIO_CTRL_WAIT_COUNTER_ENABLE]) begin
            if (!run_r) begin
              run_nxt  = 1'b1;
              wcnt_nxt = 32'h00000000;
            end
          end else begin
            run_nxt = 1'b0;
          end
        end
        `SCIO_ADR_SERSEL: ser_nxt  = wb_dat_i[1:0];
        `SCIO_ADR_STAT:   st_clr   = wb_dat_i[3:0];
        `SCIO_ADR_MASK:   mask_nxt = wb_dat_i[3:0];
        `SCIO_ADR_WT0:    wt0_nxt  = wb_dat_i[7:0];
        `SCIO_ADR_WT1:    wt1_nxt  = wb_dat_i[7:0];
        `SCIO_ADR_WT2:    wt2_nxt  = wb_dat_i[7:0];
        `SCIO_ADR_WT3:    wt3_nxt  = wb_dat_i[7:0];
        `SCIO_ADR_TXD: begin
          txd_nxt  = wb_dat_i[7:0];
          pend_nxt = 1'b1;
        end
        `SCIO_ADR_CONTACTS: begin
          if (!ser_r[`SCIO_SER_PAGE]) begin
            con_nxt = wb_dat_i[7:0];
          end
        end
        default: ;
      endcase
    end

    // sticky flags, a set in the clearing cycle wins
    stat_nxt  = (stat_r & ~st_clr) | st_set;
    ident_nxt = (ident_r & ~(wr && (wb_adr_i == `SCIO_ADR_IDENT) && wb_dat_i[0]))
              | (st_set[`SCIO_ST_PE] & mask_r[`SCIO_ST_PE]);

    // io pin: open drain, engine or software bit
    if (uart) begin
      oe_nxt = ((st_r == scio_pkg::ST_TX) & ~tx_level)
             | ((st_r == scio_pkg::ST_RX_SIG) & (bit_r == 4'h0));
    end else begin
      oe_nxt = ~con_r[`SCIO_CON_IO];
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r   <= scio_pkg::ST_IDLE;
      ack_r  <= 1'b0;
      dat_r  <= 32'h00000000;
      ctrl_r <= `SCIO_CTRL_RST;
      ser_r  <= 2'h0;
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      ident_r <= 1'b0;
      wt0_r  <= 8'h00;
      wt1_r  <= 8'h00;
      wt2_r  <= 8'h00;
      wt3_r  <= 8'h00;
      txd_r  <= 8'h00;
      rxd_r  <= 8'h00;
      con_r  <= `SCIO_CON_RST;
      run_r  <= 1'b0;
      wcnt_r <= 32'h00000000;
      hold_r <= 32'h00000000;
      wetu_r <= 9'h000;
      etu_r  <= 9'h000;
      bit_r  <= 4'h0;
      rxsh_r <= 8'h00;
      err_r  <= 1'b0;
      rep_r  <= 3'h0;
      sig_r  <= 3'h0;
      pend_r <= 1'b0;
      oe_r   <= 1'b0;
      io_s1_r <= 1'b1;
      io_s2_r <= 1'b1;
      io_s3_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      ack_r  <= ack_nxt;
      dat_r  <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      ser_r  <= ser_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      ident_r <= ident_nxt;
      wt0_r  <= wt0_nxt;
      wt1_r  <= wt1_nxt;
      wt2_r  <= wt2_nxt;
      wt3_r  <= wt3_nxt;
      txd_r  <= txd_nxt;
      rxd_r  <= rxd_nxt;
      con_r  <= con_nxt;
      run_r  <= run_nxt;
      wcnt_r <= wcnt_nxt;
      hold_r <= hold_nxt;
      wetu_r <= wetu_nxt;
      etu_r  <= etu_nxt;
      bit_r  <= bit_nxt;
      rxsh_r <= rxsh_nxt;
      err_r  <= err_nxt;
      rep_r  <= rep_nxt;
      sig_r  <= sig_nxt;
      pend_r <= pend_nxt;
      oe_r   <= oe_nxt;
      io_s1_r <= card_io_i;
      io_s2_r <= io_s1_r;
      io_s3_r <= io_s2_r;
      ck_s1_r <= card_clk_i;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end

  // ==========================================================
  // outputs
  assign wb_ack_o           = ack_r;
  assign wb_dat_o           = dat_r;
  assign irq_o              = |(stat_r & mask_r);
  assign card_io_o          = 1'b0;
  assign card_io_oe_o       = oe_r;
  assign clk_src_sel_o      = con_r[7];
  assign contact_c8_level_o = con_r[5];
  assign contact_c4_level_o = con_r[4];
  assign card_clock_level_o = con_r[2];
  assign card_reset_level_o = con_r[1];
  assign card_power_on_o    = con_r[0];

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_sw_io;
    (!uart && !$past(rst_i)) |=> card_io_oe_o == !$past(con_r[`SCIO_CON_IO]);
  endproperty
  a_sw_io: assert property (p_sw_io) else $error("io pin does not follow software bit");

  property p_wt_halt;
    (run_r && wcnt_r == hold_r) |=> (!run_r && stat_r[`SCIO_ST_WTO]);
  endproperty
  a_wt_halt: assert property (p_wt_halt) else $error("wait counter did not halt at timeout");

  property p_wt_load;
    (!run_r && !run_nxt) |=> hold_r == $past({wt3_r, wt2_r, wt1_r, wt0_r});
  endproperty
  a_wt_load: assert property (p_wt_load) else $error("hold value not reloaded while stopped");

  property p_no_sig;
    !repetition_enable |-> (st_nxt != scio_pkg::ST_RX_SIG) && !(st_r == scio_pkg::ST_TX_GUARD && st_nxt == scio_pkg::ST_TX);
  endproperty
  a_no_sig: assert property (p_no_sig) else $error("repetition activity while disabled");

  property p_sig_lim;
    sig_r <= sig_lim;
  endproperty
  a_sig_lim: assert property (p_sig_lim) else $error("too many parity error signals");

  property p_rep_lim;
    (st_r == scio_pkg::ST_TX_GUARD && st_nxt == scio_pkg::ST_TX) |-> rep_r < tx_lim;
  endproperty
  a_rep_lim: assert property (p_rep_lim) else $error("too many repetitions");

  property p_pend;
    (st_set[`SCIO_ST_PE] && mask_r[`SCIO_ST_PE]) |=> (ident_r && stat_r[`SCIO_ST_PE]);
  endproperty
  a_pend: assert property (p_pend) else $error("parity pending bit not set");

  property p_tx_level;
    (uart && st_r == scio_pkg::ST_TX && bit_r == 4'h1 && $stable(bit_r)) |=>
      card_io_oe_o == (convention_select ? $past(txd_r[7]) : !$past(txd_r[0]));
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("first data bit wrong for convention");

  property p_ctrl_rst;
    $past(rst_i) |-> (ctrl_r == 8'h00 && !run_r);
  endproperty
  a_ctrl_rst: assert property (p_ctrl_rst) else $error("control register not zero after reset");

  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held longer than one cycle");

  c_tx_rep: cover property (st_r == scio_pkg::ST_TX_GUARD ##1 st_r == scio_pkg::ST_TX);
  c_rx_sig: cover property (st_r == scio_pkg::ST_RX_SIG && card_io_oe_o);
  c_wt_to: cover property ($rose(stat_r[`SCIO_ST_WTO]));
  c_rx_ok: cover property ($rose(stat_r[`SCIO_ST_RXD]));

endmodule

// ---- test/scio_card_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// card side: free running card clock, pull-up on the io line, receiver of one character
module scio_card_model (
  input  wire logic       dut_oe_i,
  input  wire logic       arm_i,
  output logic            card_clk_o,
  output logic            io_line_o,
  output logic [7:0]      byte_o,
  output logic            par_o,
  output logic            done_o
);
  int i;

  // line has a pull-up: high unless the device pulls it low
  assign io_line_o = ~dut_oe_i;

  initial begin
    card_clk_o = 1'b0;
    forever begin
      #62 card_clk_o = 1'b1;
      #63 card_clk_o = 1'b0;
    end
  end

  // ==========================================================
  // capture one character, direct convention, mid-etu sampling
  initial begin
    byte_o = 8'h00;
    par_o  = 1'b0;
    done_o = 1'b0;
    wait (arm_i === 1'b1);
    @(negedge io_line_o);
    repeat (186) @(posedge card_clk_o);
    for (i = 0; i < 8; i++) begin
      repeat (372) @(posedge card_clk_o);
      byte_o[i] = io_line_o;
    end
    repeat (372) @(posedge card_clk_o);
    par_o  = io_line_o;
    done_o = 1'b1;
  end
endmodule

// ---- test/smart_card_io_protocol_control_bench.sv ----
`timescale 1ns/1ns
`include "scio_consts.svh"
module smart_card_io_protocol_control_bench;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        card_clk;
  logic        card_line;
  logic        card_io_o;
  logic        card_io_oe_o;
  logic [5:0]  contacts;
  logic        arm;
  logic [7:0]  cap_byte;
  logic        cap_par;
  logic        cap_done;
  logic [31:0] q;
  int          err_count;
  int          tests_run;

  scio_top dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .wb_cyc_i           (wb_cyc_i),
    .wb_stb_i           (wb_stb_i),
    .wb_we_i            (wb_we_i),
    .wb_adr_i           (wb_adr_i),
    .wb_sel_i           (wb_sel_i),
    .wb_dat_i           (wb_dat_i),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .irq_o              (irq_o),
    .card_clk_i         (card_clk),
    .card_io_i          (card_line),
    .card_io_o          (card_io_o),
    .card_io_oe_o       (card_io_oe_o),
    .clk_src_sel_o      (contacts[5]),
    .contact_c8_level_o (contacts[4]),
    .contact_c4_level_o (contacts[3]),
    .card_clock_level_o (contacts[2]),
    .card_reset_level_o (contacts[1]),
    .card_power_on_o    (contacts[0])
  );

  scio_card_model card (
    .dut_oe_i   (card_io_oe_o),
    .arm_i      (arm),
    .card_clk_o (card_clk),
    .io_line_o  (card_line),
    .byte_o     (cap_byte),
    .par_o      (cap_par),
    .done_o     (cap_done)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================
  // reporting
  task close_out;
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ==========================================================
  // classic wishbone single cycle
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      close_out();
    end
    // ack seen high at this edge: take the data, then release
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    wb(1'b1, a, d, dummy);
  endtask

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, a, 8'h00, v);
    check(name, v, exp);
  endtask

  task wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      close_out();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    err_count = 0;
    tests_run = 0;
    rst_i     = 1'b1;
    wb_cyc_i  = 1'b0;
    wb_stb_i  = 1'b0;
    wb_we_i   = 1'b0;
    wb_adr_i  = 8'h00;
    wb_sel_i  = 4'h1;
    wb_dat_i  = 32'h00000000;
    arm       = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl_reset", `SCIO_ADR_CTRL, 32'h00000000);
    rd_chk("unmapped", 8'h3c, 32'h00000000);
    // contacts: outputs follow bits, bit6 reads 0, io bit reads the pin
    wr(`SCIO_ADR_CONTACTS, 8'hbf);
    // released line needs the oe register and two sync stages before it reads back
    repeat (4) @(posedge clk_i);
    rd_chk("contacts_hi", `SCIO_ADR_CONTACTS, 32'h000000bf);
    check("contact_pins", {26'h0, contacts}, 32'h0000003f);
    check("io_released", {31'h0, card_io_oe_o}, 32'h00000000);
    wr(`SCIO_ADR_CONTACTS, 8'hb7);
    repeat (6) @(posedge clk_i);
    check("io_pulled", {30'h0, card_io_oe_o, card_io_o}, 32'h00000002);
    rd_chk("contacts_lo", `SCIO_ADR_CONTACTS, 32'h000000b7);
    wr(`SCIO_ADR_SERSEL, 8'h02);
    rd_chk("contacts_paged", `SCIO_ADR_CONTACTS, 32'h00000000);
    wr(`SCIO_ADR_SERSEL, 8'h00);
    wr(`SCIO_ADR_CONTACTS, 8'hbf);
    // waiting time counter on card clock edges, timeout of 16
    wr(`SCIO_ADR_WT0, 8'h10);
    wr(`SCIO_ADR_WT1, 8'h00);
    wr(`SCIO_ADR_WT2, 8'h00);
    wr(`SCIO_ADR_WT3, 8'h00);
    wr(`SCIO_ADR_MASK, 8'h02);
    wr(`SCIO_ADR_CTRL, 8'h04);
    repeat (100) @(posedge clk_i);
    check("wt_early", {31'h0, irq_o}, 32'h00000000);
    wait_irq(400);
    rd_chk("wt_halted", `SCIO_ADR_CTRL, 32'h00000000);
    rd_chk("wt_status", `SCIO_ADR_STAT, 32'h00000002);
    wr(`SCIO_ADR_MASK, 8'h00);
    check("irq_masked", {31'h0, irq_o}, 32'h00000000);
    wr(`SCIO_ADR_MASK, 8'h02);
    check("irq_unmasked", {31'h0, irq_o}, 32'h00000001);
    wr(`SCIO_ADR_STAT, 8'h02);
    check("irq_cleared", {31'h0, irq_o}, 32'h00000000);
    rd_chk("status_clear", `SCIO_ADR_STAT, 32'h00000000);
    // one character from the engine, direct convention, repetition off
    wr(`SCIO_ADR_CTRL, 8'h08);
    // waiting time counted in etus while the engine owns the pin, timeout of 1
    wr(`SCIO_ADR_WT0, 8'h01);
    wr(`SCIO_ADR_MASK, 8'h02);
    wr(`SCIO_ADR_CTRL, 8'h0c);
    repeat (2000) @(posedge clk_i);
    check("wt_etu_early", {31'h0, irq_o}, 32'h00000000);
    wait_irq(6000);
    rd_chk("wt_etu_status", `SCIO_ADR_STAT, 32'h00000002);
    wr(`SCIO_ADR_STAT, 8'h02);
    rd_chk("wt_etu_halted", `SCIO_ADR_CTRL, 32'h00000008);
    wr(`SCIO_ADR_MASK, 8'h04);
    repeat (10) @(posedge clk_i);
    arm <= 1'b1;
    wr(`SCIO_ADR_TXD, 8'ha5);
    wait_irq(80000);
    check("tx_seen", {31'h0, cap_done}, 32'h00000001);
    check("tx_byte", {24'h0, cap_byte}, 32'h000000a5);
    check("tx_parity", {31'h0, cap_par}, 32'h00000000);
    wb(1'b0, `SCIO_ADR_STAT, 8'h00, q);
    check("tx_status", q & 32'h00000005, 32'h00000004);
    close_out();
  end
endmodule
